// *** rtl/dss_map.svh ***
// Object indexes, field positions and reset values of the drive state
// sequencer. Included by the sequencer alone, by bare name.
// Operation
// - After reset, enter not-ready and run self-test and initialisation first.
// - When initialisation ends, move automatically to switch-on disabled.
// - Shutdown while switch-on disabled moves to ready, no further action.
// - Switch-on command moves to switched on and powers the power section.
// - Enable operation enables drive function and clears internal set-points.
// - Disable operation returns to switched on and disables drive function.
// - Shutdown cuts high power; option code adds action only from operation enabled.
// - Quick stop or disable voltage from ready: state change only.
// - Transitions 8, 9, 10 cut high power at once, motor coasts.
// - Quick stop while operation enabled starts the quick stop function.
// - Quick stop done with code 1..4, or disable voltage, goes disabled.
// - Quick stop active stops by mode, then leaves unless code says stay.
// - A fault in any state starts the configured fault reaction.
// - Fault reaction complete enters fault, drive function disabled.
// - Fault reset leaves fault only when no fault is present.
// - Enable operation in quick stop re-enables only for codes 5..8.
// - Mode-of-operation writes refused in operation enabled or quick stop.
// - No move to ready until the fieldbus master is operational.
// - Master leaving operational forces switch-on disabled and coasting.
// - Commands decode from command word bits 7, 3, 2, 1 and 0.
// - State reported in status bits 6, 5 and 3..0 per state coding.
// - Quick stop code selects disable, ramp-and-leave or ramp-and-stay.
`ifndef DSS_MAP_SVH
`define DSS_MAP_SVH

// Object indexes
`define DSS_IDX_COMMAND      16'h6040
`define DSS_IDX_STATE_REPORT 16'h6041
`define DSS_IDX_QUICK_STOP   16'h605a
`define DSS_IDX_SHUTDOWN     16'h605b
`define DSS_IDX_DISABLE_OP   16'h605c
`define DSS_IDX_HALT         16'h605d
`define DSS_IDX_FAULT_REACT  16'h605e
`define DSS_IDX_MODE_SELECT  16'h6060
`define DSS_IDX_MODE_SHOWN   16'h6061
`define DSS_IDX_QS_DECEL     16'h6085

// Command word bit positions
`define DSS_CW_SWITCH_ON     0
`define DSS_CW_ENABLE_VOLT   1
`define DSS_CW_QUICK_STOP_N  2
`define DSS_CW_ENABLE_OP     3
`define DSS_CW_FAULT_RESET   7

// State report bit positions
`define DSS_SW_READY         0
`define DSS_SW_SWITCHED_ON   1
`define DSS_SW_OP_ENABLED    2
`define DSS_SW_FAULT         3
`define DSS_SW_VOLTAGE_ON    4
`define DSS_SW_QUICK_STOP_N  5
`define DSS_SW_SO_DISABLED   6

// Reset values
`define DSS_RST_COMMAND      16'h0000
`define DSS_RST_QUICK_STOP   16'h0002
`define DSS_RST_SHUTDOWN     16'h0000
`define DSS_RST_DISABLE_OP   16'h0000
`define DSS_RST_HALT         16'h0000
`define DSS_RST_FAULT_REACT  16'h0000
`define DSS_RST_MODE         8'h00
`define DSS_RST_QS_DECEL     32'h0000_0000

`endif

// *** rtl/dss_pkg.sv ***
// Types shared by the drive state sequencer and its users.
// Assumes the object constants of dss_map.svh.
`default_nettype none
package dss_pkg;

  // Power states of the drive profile
  typedef enum logic [2:0] {
    DSS_NOT_READY   = 3'h0,
    DSS_SO_DISABLED = 3'h1,
    DSS_READY       = 3'h2,
    DSS_SWITCHED_ON = 3'h3,
    DSS_OP_ENABLED  = 3'h4,
    DSS_QUICK_STOP  = 3'h5,
    DSS_FAULT_REACT = 3'h6,
    DSS_FAULT       = 3'h7
  } dss_state_type;

  // Object write request from the fieldbus side
  typedef struct packed {
    logic        en;
    logic [15:0] index;
    logic [31:0] data;
  } dss_obj_wr_type;

  // Object read request from the fieldbus side
  typedef struct packed {
    logic        en;
    logic [15:0] index;
  } dss_obj_rd_type;

  // Controls sent to the power stage and motion logic
  typedef struct packed {
    logic self_test_run;
    logic comm_active;
    logic high_power_on;
    logic drive_function_en;
    logic setpoint_clear;
    logic quick_stop_run;
    logic quick_stop_ramp;
    logic fault_reaction_run;
    logic slow_down_req;
    logic drive_inhibit;
  } dss_drive_ctl_type;

endpackage
`default_nettype wire

// *** rtl/dss_sequencer.sv ***
// Drive state sequencer: command word decode, power state machine,
// option objects and mode-of-operation gating.
// Assumes every input but the asynchronous rst is synchronous to mclk and that the fieldbus side
// presents object accesses as single-cycle strobes.
`include "dss_map.svh"
`default_nettype none
module dss_sequencer (
  // Clock and reset
  input  wire  logic                       mclk,
  input  wire  logic                       rst,
  // Object access from the fieldbus side
  input  wire  dss_pkg::dss_obj_wr_type    obj_wr,
  output logic                             obj_wr_ack,
  output logic                             obj_wr_refused,
  input  wire  dss_pkg::dss_obj_rd_type    obj_rd,
  output logic                             obj_rd_valid,
  output logic                             obj_rd_error,
  output logic [31:0]                      obj_rd_data,
  // Status of the surrounding drive
  input  wire  logic                       init_done,
  input  wire  logic                       master_operational,
  input  wire  logic                       fault_present,
  input  wire  logic                       motor_stopped,
  input  wire  logic                       fault_reaction_done,
  // Controls to the drive
  output dss_pkg::dss_drive_ctl_type       drive_ctl,
  output dss_pkg::dss_state_type           power_state,
  output logic [7:0]                       operating_mode
);

  // Object storage
  logic [15:0]            command_word;
  logic [15:0]            quick_stop_behaviour;
  logic [15:0]            shutdown_behaviour;
  logic [15:0]            disable_op_behaviour;
  logic [15:0]            halt_behaviour;
  logic [15:0]            fault_reaction_behaviour;
  logic [7:0]             operating_mode_select;
  logic [7:0]             operating_mode_shown;
  logic [31:0]            quick_stop_decel_rate;
  logic [15:0]            state_report_word;

  // Sequencer state and decode
  dss_pkg::dss_state_type state;
  dss_pkg::dss_state_type next_state;
  logic                   cmd_new;
  logic                   fault_reset_prev;
  logic                   fault_reset_edge;
  logic                   cmd_shutdown;
  logic                   cmd_switch_on;
  logic                   cmd_enable_op;
  logic                   cmd_disable_volt;
  logic                   cmd_quick_stop;
  logic                   qs_leave_code;
  logic                   qs_stay_code;
  logic                   qs_quick_ramp;
  logic                   mode_locked;
  logic                   wr_known;
  logic                   wr_read_only;
  logic                   wr_cmd;
  logic [15:0]            next_command;
  logic                   take_setpoint_clear;
  logic                   take_slow_down;

  // Write target classification
  always_comb begin
    wr_known     = 1'b1;
    wr_read_only = 1'b0;
    unique case (obj_wr.index)
      `DSS_IDX_COMMAND,
      `DSS_IDX_QUICK_STOP,
      `DSS_IDX_SHUTDOWN,
      `DSS_IDX_DISABLE_OP,
      `DSS_IDX_HALT,
      `DSS_IDX_FAULT_REACT,
      `DSS_IDX_MODE_SELECT,
      `DSS_IDX_QS_DECEL:    wr_read_only = 1'b0;
      `DSS_IDX_STATE_REPORT,
      `DSS_IDX_MODE_SHOWN:  wr_read_only = 1'b1;
      default:              wr_known     = 1'b0;
    endcase
  end

  // Mode changes only while the motor cannot be moving under a mode
  assign mode_locked = (state == dss_pkg::DSS_OP_ENABLED) ||
                       (state == dss_pkg::DSS_QUICK_STOP);
  assign wr_cmd      = obj_wr.en && (obj_wr.index == `DSS_IDX_COMMAND);
  assign next_command = wr_cmd ? obj_wr.data[15:0] : command_word;

  // Object write acknowledge and refusal pulses
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      obj_wr_ack     <= 1'b0;
      obj_wr_refused <= 1'b0;
    end else begin
      obj_wr_ack     <= obj_wr.en && wr_known && !wr_read_only &&
                        !(obj_wr.index == `DSS_IDX_MODE_SELECT &&
                          mode_locked);
      obj_wr_refused <= obj_wr.en && (!wr_known || wr_read_only ||
                        (obj_wr.index == `DSS_IDX_MODE_SELECT &&
                         mode_locked));
    end
  end

  // Command word and its update event
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      command_word     <= `DSS_RST_COMMAND;
      cmd_new          <= 1'b0;
      fault_reset_prev <= 1'b0;
    end else begin
      command_word     <= next_command;
      cmd_new          <= wr_cmd;
      if (cmd_new) begin
        fault_reset_prev <= command_word[`DSS_CW_FAULT_RESET];
      end
    end
  end

  // Option objects
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      quick_stop_behaviour     <= `DSS_RST_QUICK_STOP;
      shutdown_behaviour       <= `DSS_RST_SHUTDOWN;
      disable_op_behaviour     <= `DSS_RST_DISABLE_OP;
      halt_behaviour           <= `DSS_RST_HALT;
      fault_reaction_behaviour <= `DSS_RST_FAULT_REACT;
      quick_stop_decel_rate    <= `DSS_RST_QS_DECEL;
    end else if (obj_wr.en) begin
      unique case (obj_wr.index)
        `DSS_IDX_QUICK_STOP:  quick_stop_behaviour     <= obj_wr.data[15:0];
        `DSS_IDX_SHUTDOWN:    shutdown_behaviour       <= obj_wr.data[15:0];
        `DSS_IDX_DISABLE_OP:  disable_op_behaviour     <= obj_wr.data[15:0];
        `DSS_IDX_HALT:        halt_behaviour           <= obj_wr.data[15:0];
        `DSS_IDX_FAULT_REACT: fault_reaction_behaviour <= obj_wr.data[15:0];
        `DSS_IDX_QS_DECEL:    quick_stop_decel_rate    <= obj_wr.data;
        default: ;
      endcase
    end
  end

  // Mode of operation: requested and shown
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      operating_mode_select <= `DSS_RST_MODE;
      operating_mode_shown  <= `DSS_RST_MODE;
    end else begin
      if (obj_wr.en && obj_wr.index == `DSS_IDX_MODE_SELECT &&
          !mode_locked) begin
        operating_mode_select <= obj_wr.data[7:0];
      end
      if (!mode_locked) begin
        operating_mode_shown <= operating_mode_select;
      end
    end
  end

  // Command decode from bits 7, 3, 2, 1 and 0
  always_comb begin
    cmd_disable_volt = !command_word[`DSS_CW_ENABLE_VOLT];
    cmd_quick_stop   = command_word[`DSS_CW_ENABLE_VOLT] &&
                       !command_word[`DSS_CW_QUICK_STOP_N];
    cmd_shutdown     = command_word[`DSS_CW_ENABLE_VOLT] &&
                       command_word[`DSS_CW_QUICK_STOP_N] &&
                       !command_word[`DSS_CW_SWITCH_ON];
    cmd_switch_on    = command_word[`DSS_CW_ENABLE_VOLT] &&
                       command_word[`DSS_CW_QUICK_STOP_N] &&
                       command_word[`DSS_CW_SWITCH_ON] &&
                       !command_word[`DSS_CW_ENABLE_OP];
    cmd_enable_op    = command_word[`DSS_CW_ENABLE_VOLT] &&
                       command_word[`DSS_CW_QUICK_STOP_N] &&
                       command_word[`DSS_CW_SWITCH_ON] &&
                       command_word[`DSS_CW_ENABLE_OP];
    // Any command with bit 7 set is a fault reset, on its rising edge
    if (command_word[`DSS_CW_FAULT_RESET]) begin
      cmd_disable_volt = 1'b0;
      cmd_quick_stop   = 1'b0;
      cmd_shutdown     = 1'b0;
      cmd_switch_on    = 1'b0;
      cmd_enable_op    = 1'b0;
    end
  end
  assign fault_reset_edge = command_word[`DSS_CW_FAULT_RESET] &&
                            !fault_reset_prev;

  // Quick stop option classes
  always_comb begin
    qs_leave_code = (quick_stop_behaviour >= 16'h0001) &&
                    (quick_stop_behaviour <= 16'h0004);
    qs_stay_code  = (quick_stop_behaviour >= 16'h0005) &&
                    (quick_stop_behaviour <= 16'h0008);
    qs_quick_ramp = (quick_stop_behaviour == 16'h0002) ||
                    (quick_stop_behaviour == 16'h0006);
  end

  // Next power state: fault first, then master loss, then one command
  always_comb begin
    next_state = state;
    unique case (state)
      dss_pkg::DSS_NOT_READY: begin
        if (init_done) begin
          next_state = dss_pkg::DSS_SO_DISABLED;
        end
      end
      dss_pkg::DSS_SO_DISABLED: begin
        if (cmd_new && cmd_shutdown && master_operational) begin
          next_state = dss_pkg::DSS_READY;
        end
      end
      dss_pkg::DSS_READY: begin
        if (cmd_new && cmd_switch_on) begin
          next_state = dss_pkg::DSS_SWITCHED_ON;
        end else if (cmd_new && cmd_enable_op) begin
          next_state = dss_pkg::DSS_SWITCHED_ON;
        end else if (cmd_new && (cmd_quick_stop || cmd_disable_volt)) begin
          next_state = dss_pkg::DSS_SO_DISABLED;
        end
      end
      dss_pkg::DSS_SWITCHED_ON: begin
        if (cmd_new && cmd_enable_op) begin
          next_state = dss_pkg::DSS_OP_ENABLED;
        end else if (cmd_new && cmd_shutdown) begin
          next_state = dss_pkg::DSS_READY;
        end else if (cmd_new && (cmd_quick_stop || cmd_disable_volt)) begin
          next_state = dss_pkg::DSS_SO_DISABLED;
        end
      end
      dss_pkg::DSS_OP_ENABLED: begin
        if (cmd_new && cmd_switch_on) begin
          next_state = dss_pkg::DSS_SWITCHED_ON;
        end else if (cmd_new && cmd_shutdown) begin
          next_state = dss_pkg::DSS_READY;
        end else if (cmd_new && cmd_disable_volt) begin
          next_state = dss_pkg::DSS_SO_DISABLED;
        end else if (cmd_new && cmd_quick_stop) begin
          next_state = dss_pkg::DSS_QUICK_STOP;
        end
      end
      dss_pkg::DSS_QUICK_STOP: begin
        if (cmd_new && cmd_disable_volt) begin
          next_state = dss_pkg::DSS_SO_DISABLED;
        end else if (cmd_new && cmd_enable_op && qs_stay_code) begin
          next_state = dss_pkg::DSS_OP_ENABLED;
        end else if (quick_stop_behaviour == 16'h0000 ||
                     (motor_stopped && qs_leave_code)) begin
          next_state = dss_pkg::DSS_SO_DISABLED;
        end
      end
      dss_pkg::DSS_FAULT_REACT: begin
        if (fault_reaction_done) begin
          next_state = dss_pkg::DSS_FAULT;
        end
      end
      dss_pkg::DSS_FAULT: begin
        if (cmd_new && fault_reset_edge && !fault_present) begin
          next_state = dss_pkg::DSS_SO_DISABLED;
        end
      end
    endcase
    // Master loss from ready, switched on, operation enabled or quick stop
    if (!master_operational &&
        (state == dss_pkg::DSS_READY || state == dss_pkg::DSS_SWITCHED_ON ||
         state == dss_pkg::DSS_OP_ENABLED ||
         state == dss_pkg::DSS_QUICK_STOP)) begin
      next_state = dss_pkg::DSS_SO_DISABLED;
    end
    // A fault overrides every command
    if (fault_present && state != dss_pkg::DSS_FAULT_REACT &&
        state != dss_pkg::DSS_FAULT) begin
      next_state = dss_pkg::DSS_FAULT_REACT;
    end
  end

  // Power state register; reset lands in not-ready for self-test
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= dss_pkg::DSS_NOT_READY;
    end else begin
      state <= next_state;
    end
  end

  // Entry actions that last one cycle
  assign take_setpoint_clear = (next_state == dss_pkg::DSS_OP_ENABLED) &&
                               (state == dss_pkg::DSS_SWITCHED_ON);
  assign take_slow_down =
    ((state == dss_pkg::DSS_OP_ENABLED) &&
     (next_state == dss_pkg::DSS_READY) && shutdown_behaviour[0]) ||
    ((state == dss_pkg::DSS_OP_ENABLED) &&
     (next_state == dss_pkg::DSS_SWITCHED_ON) && disable_op_behaviour[0]);

  // Drive controls but quick_stop_ramp are registered from next_state, so they change on the same edge as the state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      drive_ctl <= '0;
    end else begin
      drive_ctl.self_test_run <=
        (next_state == dss_pkg::DSS_NOT_READY);
      drive_ctl.comm_active <=
        (next_state != dss_pkg::DSS_NOT_READY);
      // Power stays on only in powered states; leaving cuts it at once
      drive_ctl.high_power_on <=
        (next_state == dss_pkg::DSS_SWITCHED_ON) ||
        (next_state == dss_pkg::DSS_OP_ENABLED) ||
        (next_state == dss_pkg::DSS_QUICK_STOP) ||
        (next_state == dss_pkg::DSS_FAULT_REACT);
      drive_ctl.drive_function_en <=
        (next_state == dss_pkg::DSS_OP_ENABLED);
      drive_ctl.setpoint_clear <= take_setpoint_clear;
      drive_ctl.quick_stop_run <=
        (next_state == dss_pkg::DSS_QUICK_STOP) &&
        (quick_stop_behaviour != 16'h0000);
      drive_ctl.quick_stop_ramp <= qs_quick_ramp;
      drive_ctl.fault_reaction_run <=
        (next_state == dss_pkg::DSS_FAULT_REACT);
      drive_ctl.slow_down_req <= take_slow_down;
      drive_ctl.drive_inhibit <=
        (next_state != dss_pkg::DSS_OP_ENABLED) &&
        (next_state != dss_pkg::DSS_QUICK_STOP);
    end
  end

  // State report coding in bits 6, 5 and 3..0; bit 4 mirrors high power
  always_comb begin
    state_report_word = 16'h0000;
    unique case (state)
      dss_pkg::DSS_NOT_READY:   state_report_word[6:0] = 7'h00;
      dss_pkg::DSS_SO_DISABLED: state_report_word[6:0] = 7'h40;
      dss_pkg::DSS_READY:       state_report_word[6:0] = 7'h21;
      dss_pkg::DSS_SWITCHED_ON: state_report_word[6:0] = 7'h23;
      dss_pkg::DSS_OP_ENABLED:  state_report_word[6:0] = 7'h27;
      dss_pkg::DSS_QUICK_STOP:  state_report_word[6:0] = 7'h07;
      dss_pkg::DSS_FAULT_REACT: state_report_word[6:0] = 7'h0f;
      dss_pkg::DSS_FAULT:       state_report_word[6:0] = 7'h08;
    endcase
    state_report_word[`DSS_SW_VOLTAGE_ON] = drive_ctl.high_power_on;
  end

  // Object read answer one cycle after the request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      obj_rd_valid <= 1'b0;
      obj_rd_error <= 1'b0;
      obj_rd_data  <= 32'h0000_0000;
    end else begin
      obj_rd_valid <= obj_rd.en;
      obj_rd_error <= 1'b0;
      if (obj_rd.en) begin
        unique case (obj_rd.index)
          `DSS_IDX_COMMAND:      obj_rd_data <= {16'h0000, command_word};
          `DSS_IDX_STATE_REPORT: obj_rd_data <= {16'h0000,
                                                 state_report_word};
          `DSS_IDX_QUICK_STOP:   obj_rd_data <= {16'h0000,
                                                 quick_stop_behaviour};
          `DSS_IDX_SHUTDOWN:     obj_rd_data <= {16'h0000,
                                                 shutdown_behaviour};
          `DSS_IDX_DISABLE_OP:   obj_rd_data <= {16'h0000,
                                                 disable_op_behaviour};
          `DSS_IDX_HALT:         obj_rd_data <= {16'h0000, halt_behaviour};
          `DSS_IDX_FAULT_REACT:  obj_rd_data <= {16'h0000,
                                                 fault_reaction_behaviour};
          `DSS_IDX_MODE_SELECT:  obj_rd_data <= {24'h000000,
                                                 operating_mode_select};
          `DSS_IDX_MODE_SHOWN:   obj_rd_data <= {24'h000000,
                                                 operating_mode_shown};
          `DSS_IDX_QS_DECEL:     obj_rd_data <= quick_stop_decel_rate;
          default: begin
            obj_rd_data  <= 32'h0000_0000;
            obj_rd_error <= 1'b1;
          end
        endcase
      end
    end
  end

  // Visible state and active mode
  assign power_state    = state;
  assign operating_mode = operating_mode_shown;

endmodule
`default_nettype wire

// *** tb/dss_seq_asserts.sv ***
// Checker for the drive state sequencer, bound to its top ports.
// Assumes one mclk domain and an active-high asynchronous rst.
`default_nettype none
module dss_seq_asserts (
  // Clock and reset
  input wire logic                       mclk,
  input wire logic                       rst,
  // Object writes
  input wire dss_pkg::dss_obj_wr_type    obj_wr,
  input wire logic                       obj_wr_refused,
  input wire logic                       obj_wr_ack,
  // Drive status
  input wire logic                       init_done,
  input wire logic                       master_operational,
  input wire logic                       fault_present,
  input wire logic                       fault_reaction_done,
  // Drive controls and state
  input wire dss_pkg::dss_drive_ctl_type drive_ctl,
  input wire dss_pkg::dss_state_type     power_state,
  input wire logic [7:0]                 operating_mode
);
  // State groups used by several properties
  wire logic locked = power_state inside {dss_pkg::DSS_OP_ENABLED,
    dss_pkg::DSS_QUICK_STOP};
  wire logic live = locked || power_state inside {dss_pkg::DSS_READY,
    dss_pkg::DSS_SWITCHED_ON};
  wire logic nr = power_state == dss_pkg::DSS_NOT_READY;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Step causes
  sequence s_mode_wr; obj_wr.en && obj_wr.index == 16'h6060 && locked; endsequence
  sequence s_fault_new; fault_present && power_state < dss_pkg::DSS_FAULT_REACT;
  endsequence
  // Properties
  a_mode_refused: assert property (s_mode_wr |=> obj_wr_refused)
    else $error("mode write accepted while locked");
  a_mode_held: assert property (locked && $past(locked) |-> $stable(operating_mode))
    else $error("mode changed while locked");
  a_wr_answer: assert property (obj_wr.en |=> obj_wr_ack != obj_wr_refused)
    else $error("write not answered once");
  a_self_test: assert property (nr && !init_done && !fault_present
    |=> nr && drive_ctl.self_test_run) else $error("self test not held");
  a_init_auto: assert property (nr && init_done && !fault_present
    |=> power_state == dss_pkg::DSS_SO_DISABLED) else $error("no auto move");
  a_fault_entry: assert property (s_fault_new |=> drive_ctl.fault_reaction_run
    && power_state == dss_pkg::DSS_FAULT_REACT) else $error("fault missed");
  a_fault_done: assert property (power_state == dss_pkg::DSS_FAULT_REACT
    && fault_reaction_done |=> power_state == dss_pkg::DSS_FAULT
    && !drive_ctl.drive_function_en) else $error("fault state missed");
  a_master_loss: assert property (!master_operational && !fault_present && live
    |=> power_state == dss_pkg::DSS_SO_DISABLED && drive_ctl.drive_inhibit)
    else $error("master loss ignored");
  a_master_wait: assert property (!master_operational
    |=> power_state != dss_pkg::DSS_READY) else $error("ready without master");
  a_setpoint_clr: assert property (power_state == dss_pkg::DSS_OP_ENABLED
    && $past(power_state) == dss_pkg::DSS_SWITCHED_ON |-> drive_ctl.setpoint_clear
    && drive_ctl.drive_function_en) else $error("enable entry wrong");
endmodule
`default_nettype wire

// *** tb/dss_master_model.sv ***
// Fieldbus master model: object writes and reads as one-cycle strobes.
// Assumes a free-running mclk; strobes change 1 ns after its rising edge.
`default_nettype none
module dss_master_model (
  // Clock
  input  wire logic                   mclk,
  // Object requests
  output var dss_pkg::dss_obj_wr_type obj_wr,
  output var dss_pkg::dss_obj_rd_type obj_rd
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus at start
  initial begin
    obj_wr = '0;
    obj_rd = '0;
  end
  // One strobe per object write; released lines show inverted index and data
  task automatic wr(input logic [15:0] idx, input logic [31:0] data);
    @(posedge mclk);
    #1 obj_wr = '{1'b1, idx, data};
    @(posedge mclk);
    #1 obj_wr = '{1'b0, ~idx, ~data};
  endtask
  // Read strobe, released with inverted index
  task automatic rd(input logic [15:0] idx);
    @(posedge mclk);
    #1 obj_rd = '{1'b1, idx};
    @(posedge mclk);
    #1 obj_rd = '{1'b0, ~idx};
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Bench for the drive state sequencer: commands, reports, locks, faults.
// Assumes the master model and the checker are compiled before it.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0, rst = 1'b1, init_done = 1'b0, fault_present = 1'b0;
  logic master_operational = 1'b0, motor_stopped = 1'b0, fr_done = 1'b0;
  logic obj_rd_valid;
  logic [31:0] obj_rd_data, seed = 32'h0001_0052;
  logic [63:0] exp_q[$], m_e;
  logic [7:0] operating_mode;
  int fail_count = 0, checks_done = 0;
  dss_pkg::dss_obj_wr_type obj_wr;
  dss_pkg::dss_obj_rd_type obj_rd;
  dss_pkg::dss_drive_ctl_type drive_ctl;
  dss_pkg::dss_state_type power_state;
  localparam dss_pkg::dss_state_type sod = dss_pkg::DSS_SO_DISABLED;
  localparam dss_pkg::dss_state_type rdy = dss_pkg::DSS_READY;
  localparam dss_pkg::dss_state_type son = dss_pkg::DSS_SWITCHED_ON;
  localparam dss_pkg::dss_state_type oe = dss_pkg::DSS_OP_ENABLED;
  localparam dss_pkg::dss_state_type qs = dss_pkg::DSS_QUICK_STOP;
  // Command words
  localparam logic [15:0] c_sh = 16'h0006, c_on = 16'h0007;
  localparam logic [15:0] c_en = 16'h000f, c_qs = 16'h000b;
  localparam logic [15:0] c_off = 16'h0000, c_rs = 16'h0080;
  // Report bits 6, 5 and 3..0 per state
  logic [6:0] code_tab [8] = '{7'h00, 7'h40, 7'h21, 7'h23, 7'h27, 7'h07,
    7'h0f, 7'h08};
  // Clock
  always #5 mclk = ~mclk;
  // Design and fieldbus master
  dss_sequencer u_dut (.mclk(mclk), .rst(rst), .obj_wr(obj_wr),
    .obj_wr_ack(), .obj_wr_refused(), .obj_rd(obj_rd),
    .obj_rd_valid(obj_rd_valid), .obj_rd_error(), .obj_rd_data(obj_rd_data),
    .init_done(init_done), .master_operational(master_operational),
    .fault_present(fault_present), .motor_stopped(motor_stopped),
    .fault_reaction_done(fr_done), .drive_ctl(drive_ctl),
    .power_state(power_state), .operating_mode(operating_mode));
  dss_master_model u_master (.mclk(mclk), .obj_wr(obj_wr), .obj_rd(obj_rd));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Write a command, check the state, note the expected report
  task automatic step(input logic [15:0] cw, input dss_pkg::dss_state_type s);
    u_master.wr(16'h6040, {16'h0000, cw});
    repeat (2) @(posedge mclk);
    #1 check("state", {29'h0, power_state}, {29'h0, s});
    exp_q.push_back({32'h0000_006f, 25'h0, code_tab[s]});
    u_master.rd(16'h6041);
  endtask
  // Read results against the oldest note
  always @(negedge mclk) if (obj_rd_valid === 1'b1) begin
    m_e = exp_q.pop_front();
    check("read", obj_rd_data & m_e[63:32], m_e[31:0]);
  end
  // Watchdog
  initial begin
    #50000 fail_count++;
    give_verdict();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    step(c_sh, dss_pkg::DSS_NOT_READY);
    init_done = 1'b1;
    step(c_sh, sod);
    master_operational = 1'b1;
    step(c_sh, rdy);
    step(c_qs, sod);
    step(c_sh, rdy);
    step(c_on, son);
    step(c_en, oe);
    seed = lfsr(seed);
    u_master.wr(16'h6060, {24'h0, seed[7:0] | 8'h01});
    exp_q.push_back({32'h0000_00ff, 32'h0});
    u_master.rd(16'h6060);
    check("mode", {24'h0, operating_mode}, 32'h0);
    step(c_on, son);
    step(c_en, oe);
    step(c_qs, qs);
    motor_stopped = 1'b1;
    step(c_qs, sod);
    $display("test power states done");
    seed = lfsr(seed);
    u_master.wr(16'h605a, 32'h0000_0005 + {31'h0, seed[0]});
    motor_stopped = 1'b0;
    step(c_sh, rdy);
    step(c_on, son);
    step(c_en, oe);
    step(c_qs, qs);
    motor_stopped = 1'b1;
    step(c_qs, qs);
    step(c_en, oe);
    step(c_off, sod);
    step(c_sh, rdy);
    step(c_on, son);
    master_operational = 1'b0;
    repeat (2) @(posedge mclk);
    #1 check("loss", {power_state, drive_ctl.drive_inhibit}, {sod, 1'b1});
    master_operational = 1'b1;
    $display("test quick stop and master loss done");
    fault_present = 1'b1;
    step(c_en, dss_pkg::DSS_FAULT_REACT);
    fr_done = 1'b1;
    step(c_rs, dss_pkg::DSS_FAULT);
    fr_done = 1'b0;
    fault_present = 1'b0;
    step(c_off, dss_pkg::DSS_FAULT);
    step(c_rs, sod);
    step(c_off, sod);
    repeat (4) @(posedge mclk);
    $display("test fault handling done");
    give_verdict();
  end
endmodule
// Checker beside the sequencer
bind dss_sequencer dss_seq_asserts u_chk (.mclk(mclk), .rst(rst),
  .obj_wr(obj_wr), .obj_wr_refused(obj_wr_refused), .init_done(init_done),
  .obj_wr_ack(obj_wr_ack),
  .master_operational(master_operational), .fault_present(fault_present),
  .fault_reaction_done(fault_reaction_done), .drive_ctl(drive_ctl),
  .power_state(power_state), .operating_mode(operating_mode));
`default_nettype wire
